// *** src/cdt_top.sv ***
// Down counter, on/off-delay timer and pulse timer on discrete I/O.
// Assumes field_in synchronous to clk_sys and a classic Wishbone master.
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ns
module cdt_top
#(
  parameter int CYC_PER_MS_P = cdt_pkg::CYC_PER_MS
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cdt_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] field_in,
  output logic count_out,
  output logic delay_out,
  output logic pulse_out
);
  import cdt_pkg::*;

  localparam int PADW = 32 - VAL_W;

  function automatic logic [31:0] wb_merge(input logic [31:0] old,
    input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (sel[i]) m[8*i +: 8] = dat[8*i +: 8];
    return m;
  endfunction

  function automatic logic [VAL_W-1:0] clamp_val(input logic [31:0] v);
    return (v > {{PADW{1'b0}}, VAL_MAX}) ? VAL_MAX : v[VAL_W-1:0];
  endfunction

  function automatic logic [31:0] zx(input logic [VAL_W-1:0] v);
    return {{PADW{1'b0}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  cdt_ctrl_t ctrl_r;
  cdt_ctrl_t ctrl_nxt;
  logic [VAL_W-1:0] count_preset_r, count_preset_nxt;
  logic [VAL_W-1:0] on_preset_time_r, on_preset_time_nxt;
  logic [VAL_W-1:0] off_preset_time_r, off_preset_time_nxt;
  logic [VAL_W-1:0] pulse_preset_r, pulse_preset_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [31:0] rd_mux;
  logic req, wr;
  cdt_status_t status;

  logic [VAL_W-1:0] current_count_r, current_count_nxt;
  logic count_out_r, count_out_nxt;
  cdt_dly_st_t dly_st_r, dly_st_nxt;
  logic [VAL_W-1:0] elapsed_time_r, elapsed_time_nxt;
  logic [VAL_W-1:0] off_elapsed_time_r, off_elapsed_time_nxt;
  logic delay_out_r, delay_out_nxt;
  cdt_pls_st_t pls_st_r, pls_st_nxt;
  logic [VAL_W-1:0] pulse_elapsed_r, pulse_elapsed_nxt;
  logic pulse_out_r, pulse_out_nxt;

  cdt_tick_t tick;
  logic [3:0] tick_v;
  logic dly_tick, pls_tick;
  logic run, load_lvl;
  logic [2:0] edge_lvl, edge_rise, edge_fall;

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign count_out = count_out_r;
  assign delay_out = delay_out_r;
  assign pulse_out = pulse_out_r;

  ////////////////////////////////////////////////////////////////////////
  cdt_tick_gen #(.CYC_PER_MS_P(CYC_PER_MS_P)) u_tick
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick(tick)
  );

  // Changing a select while running can show one false edge
  assign edge_lvl = {field_in[ctrl_r.pulse_sel], field_in[ctrl_r.trig_sel],
                     field_in[ctrl_r.clk_sel]};
  assign load_lvl = field_in[ctrl_r.load_sel];

  cdt_edge #(.W(3)) u_edge
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .lvl(edge_lvl),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  assign run = ctrl_r.run;
  assign tick_v = tick;
  assign dly_tick = tick_v[ctrl_r.delay_res];
  assign pls_tick = tick_v[ctrl_r.pulse_res];

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, write lands on the acknowledged edge
  always_comb
  begin
    status = '0;
    status.inputs = field_in;
    status.pulse_st = pls_st_r;
    status.delay_st = dly_st_r;
    status.pulse_q = pulse_out_r;
    status.delay_q = delay_out_r;
    status.count_q = count_out_r;
    case (wb_adr_i)
      OFS_CTRL: rd_mux = ctrl_r;
      OFS_COUNT_PRESET: rd_mux = zx(count_preset_r);
      OFS_CURRENT_COUNT: rd_mux = zx(current_count_r);
      OFS_ON_PRESET_TIME: rd_mux = zx(on_preset_time_r);
      OFS_OFF_PRESET_TIME: rd_mux = zx(off_preset_time_r);
      OFS_PULSE_PRESET: rd_mux = zx(pulse_preset_r);
      OFS_ELAPSED_TIME: rd_mux = zx(elapsed_time_r);
      OFS_OFF_ELAPSED_TIME: rd_mux = zx(off_elapsed_time_r);
      OFS_PULSE_ELAPSED: rd_mux = zx(pulse_elapsed_r);
      OFS_STATUS: rd_mux = status;
      default: rd_mux = 32'h0000_0000;
    endcase
    req = wb_cyc_i && wb_stb_i;
    wr = req && wb_we_i && ack_r;
    ack_nxt = req && !ack_r;
    dat_nxt = (req && !ack_r) ? rd_mux : dat_r;
    ctrl_nxt = ctrl_r;
    count_preset_nxt = count_preset_r;
    on_preset_time_nxt = on_preset_time_r;
    off_preset_time_nxt = off_preset_time_r;
    pulse_preset_nxt = pulse_preset_r;
    if (wr)
    begin
      case (wb_adr_i)
        OFS_CTRL:
        begin
          ctrl_nxt = wb_merge(ctrl_r, wb_dat_i, wb_sel_i);
          ctrl_nxt.rsvd = '0;
        end
        OFS_COUNT_PRESET: count_preset_nxt = clamp_val(
          wb_merge(zx(count_preset_r), wb_dat_i, wb_sel_i));
        OFS_ON_PRESET_TIME: on_preset_time_nxt = clamp_val(
          wb_merge(zx(on_preset_time_r), wb_dat_i, wb_sel_i));
        OFS_OFF_PRESET_TIME: off_preset_time_nxt = clamp_val(
          wb_merge(zx(off_preset_time_r), wb_dat_i, wb_sel_i));
        OFS_PULSE_PRESET: pulse_preset_nxt = clamp_val(
          wb_merge(zx(pulse_preset_r), wb_dat_i, wb_sel_i));
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      ctrl_r <= CTRL_RST;
      count_preset_r <= COUNT_PRESET_RST;
      on_preset_time_r <= ON_PRESET_RST;
      off_preset_time_r <= OFF_PRESET_RST;
      pulse_preset_r <= PULSE_PRESET_RST;
    end
    else
    begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ctrl_r <= ctrl_nxt;
      count_preset_r <= count_preset_nxt;
      on_preset_time_r <= on_preset_time_nxt;
      off_preset_time_r <= off_preset_time_nxt;
      pulse_preset_r <= pulse_preset_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Down counter; load is a level and wins over a count edge
  always_comb
  begin
    current_count_nxt = current_count_r;
    count_out_nxt = count_out_r;
    if (run)
    begin
      if (load_lvl)
        current_count_nxt = count_preset_r;
      else if (edge_rise[0] && current_count_r != '0)
        current_count_nxt = current_count_r - 1'b1;
      count_out_nxt = (current_count_nxt == '0);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      current_count_r <= COUNT_PRESET_RST;
      count_out_r <= 1'b0;
    end
    else
    begin
      current_count_r <= current_count_nxt;
      count_out_r <= count_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // On/off-delay timer; >= guards against a preset lowered mid-interval
  always_comb
  begin
    dly_st_nxt = dly_st_r;
    elapsed_time_nxt = elapsed_time_r;
    off_elapsed_time_nxt = off_elapsed_time_r;
    delay_out_nxt = delay_out_r;
    if (run)
    begin
      case (dly_st_r)
        DLY_IDLE:
          if (edge_rise[1])
          begin
            dly_st_nxt = DLY_ON_WAIT;
            elapsed_time_nxt = '0;
          end
        DLY_ON_WAIT, DLY_ON:
          if (edge_fall[1])
          begin
            dly_st_nxt = DLY_OFF_WAIT;
            elapsed_time_nxt = '0;
            off_elapsed_time_nxt = '0;
          end
          else if (dly_st_r == DLY_ON_WAIT)
          begin
            if (elapsed_time_r >= on_preset_time_r)
            begin
              dly_st_nxt = DLY_ON;
              delay_out_nxt = 1'b1;
            end
            else if (dly_tick)
              elapsed_time_nxt = elapsed_time_r + 1'b1;
          end
        DLY_OFF_WAIT:
          if (edge_rise[1])
          begin
            dly_st_nxt = DLY_ON_WAIT;
            elapsed_time_nxt = '0;
          end
          else if (off_elapsed_time_r >= off_preset_time_r)
          begin
            dly_st_nxt = DLY_IDLE;
            delay_out_nxt = 1'b0;
          end
          else if (dly_tick)
            off_elapsed_time_nxt = off_elapsed_time_r + 1'b1;
        default:
        begin
          dly_st_nxt = DLY_IDLE;
          delay_out_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dly_st_r <= DLY_IDLE;
      elapsed_time_r <= '0;
      off_elapsed_time_r <= '0;
      delay_out_r <= 1'b0;
    end
    else
    begin
      dly_st_r <= dly_st_nxt;
      elapsed_time_r <= elapsed_time_nxt;
      off_elapsed_time_r <= off_elapsed_time_nxt;
      delay_out_r <= delay_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse timer; a running pulse is never retriggered
  always_comb
  begin
    pls_st_nxt = pls_st_r;
    pulse_elapsed_nxt = pulse_elapsed_r;
    pulse_out_nxt = pulse_out_r;
    if (run)
    begin
      case (pls_st_r)
        PLS_IDLE:
          if (edge_rise[2])
          begin
            pls_st_nxt = PLS_ACTIVE;
            pulse_elapsed_nxt = '0;
            pulse_out_nxt = 1'b1;
          end
        PLS_ACTIVE:
          if (pulse_elapsed_r >= pulse_preset_r)
          begin
            pls_st_nxt = PLS_IDLE;
            pulse_out_nxt = 1'b0;
          end
          else if (pls_tick)
            pulse_elapsed_nxt = pulse_elapsed_r + 1'b1;
        default:
        begin
          pls_st_nxt = PLS_IDLE;
          pulse_out_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pls_st_r <= PLS_IDLE;
      pulse_elapsed_r <= '0;
      pulse_out_r <= 1'b0;
    end
    else
    begin
      pls_st_r <= pls_st_nxt;
      pulse_elapsed_r <= pulse_elapsed_nxt;
      pulse_out_r <= pulse_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_cnt_step;
    run && !load_lvl && edge_rise[0] && current_count_r != '0 |=>
      current_count_r == $past(current_count_r) - 1'b1;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("count did not step down by one");

  property p_cnt_out;
    count_out_r == (current_count_r == '0);
  endproperty
  a_cnt_out: assert property (p_cnt_out)
    else $error("counter output disagrees with zero count");

  property p_cnt_load;
    run && load_lvl |=> current_count_r == $past(count_preset_r);
  endproperty
  a_cnt_load: assert property (p_cnt_load)
    else $error("load did not copy the preset");

  property p_cnt_range;
    current_count_r <= VAL_MAX && count_preset_r <= VAL_MAX;
  endproperty
  a_cnt_range: assert property (p_cnt_range)
    else $error("count beyond five digits");

  property p_dly_on;
    run && dly_st_r == DLY_ON_WAIT && !edge_fall[1] &&
      elapsed_time_r >= on_preset_time_r |=> delay_out_r ##1 delay_out_r;
  endproperty
  a_dly_on: assert property (p_dly_on)
    else $error("delay output not set at on preset");

  property p_dly_off;
    run && dly_st_r == DLY_OFF_WAIT && !edge_rise[1] &&
      off_elapsed_time_r >= off_preset_time_r |=> !delay_out_r;
  endproperty
  a_dly_off: assert property (p_dly_off)
    else $error("delay output not cleared at off preset");

  property p_dly_clear;
    run && edge_fall[1] && (dly_st_r == DLY_ON || dly_st_r == DLY_ON_WAIT)
      |=> off_elapsed_time_r == '0 && elapsed_time_r == '0 &&
      dly_st_r == DLY_OFF_WAIT;
  endproperty
  a_dly_clear: assert property (p_dly_clear)
    else $error("falling trigger did not clear elapsed time");

  property p_dly_hold;
    run && dly_st_r == DLY_ON_WAIT && !edge_fall[1] && !dly_tick &&
      elapsed_time_r < on_preset_time_r |=> $stable(elapsed_time_r);
  endproperty
  a_dly_hold: assert property (p_dly_hold)
    else $error("elapsed time moved without a resolution tick");

  sequence s_pls_trig;
    run && pls_st_r == PLS_IDLE && edge_rise[2];
  endsequence

  sequence s_pls_busy;
    run && pls_st_r == PLS_ACTIVE && pulse_elapsed_r < pulse_preset_r;
  endsequence

  property p_pls_start;
    s_pls_trig |=> pulse_out_r && pulse_elapsed_r == '0;
  endproperty
  a_pls_start: assert property (p_pls_start)
    else $error("pulse did not start on trigger");

  property p_pls_end;
    run && pls_st_r == PLS_ACTIVE && pulse_elapsed_r >= pulse_preset_r
      |=> !pulse_out_r;
  endproperty
  a_pls_end: assert property (p_pls_end)
    else $error("pulse did not end at preset");

  property p_pls_noretrig;
    s_pls_busy ##0 edge_rise[2] |=>
      pulse_out_r && pulse_elapsed_r >= $past(pulse_elapsed_r);
  endproperty
  a_pls_noretrig: assert property (p_pls_noretrig)
    else $error("pulse restarted by a new trigger");

  property p_freeze;
    !run |=> $stable(current_count_r) && $stable(dly_st_r) &&
      $stable(pls_st_r);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state changed outside run mode");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held for more than one cycle");

endmodule

// *** common/cdt_pkg.sv ***
// Shared constants, layouts and state codes of the counter/timer block.
// Assumes one 50 MHz system clock and a 32-bit classic Wishbone bus.
package cdt_pkg;

  localparam int ADR_W = 8;
  localparam int VAL_W = 17;
  // Five decimal digits, 99999, also 99 s 999 ms
  localparam logic [VAL_W-1:0] VAL_MAX = 17'h1_869F;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_COUNT_PRESET = 8'h04;
  localparam logic [ADR_W-1:0] OFS_CURRENT_COUNT = 8'h08;
  localparam logic [ADR_W-1:0] OFS_ON_PRESET_TIME = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_OFF_PRESET_TIME = 8'h10;
  localparam logic [ADR_W-1:0] OFS_PULSE_PRESET = 8'h14;
  localparam logic [ADR_W-1:0] OFS_ELAPSED_TIME = 8'h18;
  localparam logic [ADR_W-1:0] OFS_OFF_ELAPSED_TIME = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_PULSE_ELAPSED = 8'h20;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h24;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [VAL_W-1:0] COUNT_PRESET_RST = 17'h0_000A;
  localparam logic [VAL_W-1:0] ON_PRESET_RST = 17'h0_3A98;
  localparam logic [VAL_W-1:0] OFF_PRESET_RST = 17'h0_4E20;
  localparam logic [VAL_W-1:0] PULSE_PRESET_RST = 17'h0_3A98;

  ////////////////////////////////////////////////////////////////////////
  localparam int CLK_PERIOD_NS = 32'h0000_0014;
  localparam int MS_NS = 32'h000F_4240;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam logic [3:0] DEC_LAST = 4'h9;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0]
  {
    RES_MS = 2'h0,
    RES_10MS = 2'h1,
    RES_100MS = 2'h2,
    RES_S = 2'h3
  } cdt_res_t;

  typedef struct packed
  {
    logic [14:0] rsvd;
    cdt_res_t pulse_res;
    cdt_res_t delay_res;
    logic [2:0] pulse_sel;
    logic [2:0] trig_sel;
    logic [2:0] load_sel;
    logic [2:0] clk_sel;
    logic run;
  } cdt_ctrl_t;

  typedef struct packed
  {
    logic [14:0] rsvd;
    logic [7:0] inputs;
    logic [1:0] pulse_st;
    logic [3:0] delay_st;
    logic pulse_q;
    logic delay_q;
    logic count_q;
  } cdt_status_t;

  typedef struct packed
  {
    logic s1;
    logic ms100;
    logic ms10;
    logic ms1;
  } cdt_tick_t;

  typedef enum logic [3:0]
  {
    DLY_IDLE = 4'b0001,
    DLY_ON_WAIT = 4'b0010,
    DLY_ON = 4'b0100,
    DLY_OFF_WAIT = 4'b1000
  } cdt_dly_st_t;

  typedef enum logic [1:0]
  {
    PLS_IDLE = 2'b01,
    PLS_ACTIVE = 2'b10
  } cdt_pls_st_t;

endpackage

// *** src/cdt_tick_gen.sv ***
// Time base: millisecond tick and its decades as one-cycle enables.
// Assumes clk_sys free running; the prescale count can be shortened.
`timescale 1ns/1ns
module cdt_tick_gen
#(
  parameter int CYC_PER_MS_P = cdt_pkg::CYC_PER_MS
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  output cdt_pkg::cdt_tick_t tick
);
  import cdt_pkg::*;

  localparam int PRE_W = $clog2(CYC_PER_MS_P) + 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS_P - 1);

  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [2:0][3:0] dec_r;
  logic [2:0][3:0] dec_nxt;
  logic [3:0] t;

  assign tick = cdt_tick_t'(t);

  // Decades share one prescaler so all rates stay phase aligned
  always_comb
  begin
    t[0] = (pre_r == PRE_LAST);
    pre_nxt = t[0] ? '0 : pre_r + 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      dec_nxt[k] = dec_r[k];
      if (t[k])
        dec_nxt[k] = (dec_r[k] == DEC_LAST) ? 4'h0 : dec_r[k] + 4'h1;
      t[k+1] = t[k] && (dec_r[k] == DEC_LAST);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_r <= '0;
      dec_r <= '0;
    end
    else
    begin
      pre_r <= pre_nxt;
      dec_r <= dec_nxt;
    end
  end

  property p_s1_on_ms;
    @(posedge clk_sys) disable iff (!reset_n)
      tick.s1 |-> tick.ms1 && tick.ms10 && tick.ms100;
  endproperty
  a_s1_on_ms: assert property (p_s1_on_ms)
    else $error("second tick not aligned to millisecond tick");

endmodule

// *** src/cdt_edge.sv ***
// Edge detector for a group of sampled levels.
// Assumes the levels are already synchronous to clk_sys.
`timescale 1ns/1ns
module cdt_edge
#(
  parameter int W = 3
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;

  always_comb
  begin
    prev_nxt = lvl;
    rise = lvl & ~prev_r;
    fall = ~lvl & prev_r;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      prev_r <= '0;
    else
      prev_r <= prev_nxt;
  end

  property p_rise_cause;
    @(posedge clk_sys) disable iff (!reset_n)
      rise[0] |-> lvl[0] && !$past(lvl[0]);
  endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("rise without low-to-high change");

endmodule

// *** tb/cdt_field_model.sv ***
// Field wiring model: push buttons on the discrete inputs, lights on outputs.
// Assumes the bench calls push from one process at a time.
`timescale 1ns/1ns
module cdt_field_model
(
  input wire logic clk_sys,
  input wire logic [2:0] lights,
  output logic [7:0] field_in
);
  initial field_in = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // A button changes just after an edge and holds for whole cycles, so the
  // block never sees a glitch shorter than its sampling period
  task automatic push(input int idx, input logic lvl);
    @(posedge clk_sys);
    field_in[idx] <= lvl;
  endtask
endmodule

// *** tb/cdt_top_tb.sv ***
// Self-checking bench of the counter and timer block.
// Assumes a 4-cycle millisecond tick and the button model on field_in.
`timescale 1ns/1ns
module cdt_top_tb;
  import cdt_pkg::*;
  localparam logic [31:0] CTRL_GO = 32'h0000_11A3;
  logic clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, field_in;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic count_out, delay_out, pulse_out, ok;
  logic [2:0] outs;
  int fail_count, n_tests, seed, i, n, p, p2, u;
  longint t;
  logic [7:0] adr_t [7];
  logic [31:0] rst_t [7];

  assign outs = {pulse_out, delay_out, count_out};

  cdt_top #(.CYC_PER_MS_P(4)) i_cdt_top (.clk_sys(clk_sys),
    .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .field_in(field_in), .count_out(count_out), .delay_out(delay_out),
    .pulse_out(pulse_out));

  cdt_field_model i_cdt_field_model (.clk_sys(clk_sys), .lights(outs),
    .field_in(field_in));

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One classic cycle; the request holds until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr,
    input logic [31:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 50);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (k >= 50)
      check(32'h0000_0000, 32'h0000_0001);
  endtask

  // Cycles until an output reaches a level, bounded
  task automatic meas(input int idx, input logic lvl, output int k);
    k = 0;
    while (outs[idx] !== lvl && k < 4000)
    begin
      @(posedge clk_sys);
      k++;
    end
  endtask

  function automatic logic [31:0] exp_cnt(input int pulses);
    return (pulses >= 10) ? 32'h0000_0000 : 32'(10 - pulses);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    results();
  end

  initial
  begin
    seed = 83968;
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    adr_t = '{OFS_CTRL, OFS_COUNT_PRESET, OFS_CURRENT_COUNT,
      OFS_ON_PRESET_TIME, OFS_OFF_PRESET_TIME, OFS_PULSE_PRESET, 8'h40};
    rst_t = '{CTRL_RST, 32'(COUNT_PRESET_RST), 32'(COUNT_PRESET_RST),
      32'(ON_PRESET_RST), 32'(OFF_PRESET_RST), 32'(PULSE_PRESET_RST), 0};
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (i = 0; i < 7; i++)
    begin
      bus(1'b0, adr_t[i], 32'h0000_0000, q);
      check(q, rst_t[i]);
    end
    // Counter: load, then eleven count pulses at random spacing
    bus(1'b1, OFS_CTRL, CTRL_GO, q);
    i_cdt_field_model.push(2, 1'b1);
    i_cdt_field_model.push(2, 1'b0);
    bus(1'b0, OFS_CURRENT_COUNT, 32'h0000_0000, q);
    check(q, 32'h0000_000A);
    check(32'(count_out), 32'h0000_0000);
    for (i = 1; i <= 11; i++)
    begin
      repeat ({$random(seed)} % 4) @(posedge clk_sys);
      i_cdt_field_model.push(1, 1'b1);
      i_cdt_field_model.push(1, 1'b0);
      bus(1'b0, OFS_CURRENT_COUNT, 32'h0000_0000, q);
      check(q, exp_cnt(i));
      check(32'(count_out), 32'(i >= 10));
    end
    // Count register is read-only; stopped mode ignores the load button
    bus(1'b1, OFS_CURRENT_COUNT, $random(seed), q);
    bus(1'b1, OFS_CTRL, CTRL_GO & 32'hFFFF_FFFE, q);
    i_cdt_field_model.push(2, 1'b1);
    i_cdt_field_model.push(2, 1'b0);
    bus(1'b0, OFS_CURRENT_COUNT, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    bus(1'b1, OFS_CTRL, CTRL_GO, q);
    // Delay timer with unequal on and off presets
    p = 3 + {$random(seed)} % 6;
    p2 = p + 3;
    bus(1'b1, OFS_ON_PRESET_TIME, 32'(p), q);
    bus(1'b1, OFS_OFF_PRESET_TIME, 32'(p2), q);
    i_cdt_field_model.push(3, 1'b1);
    meas(1, 1'b1, n);
    check(32'(n >= (p - 1) * 4 && n <= (p + 1) * 4 + 4), 1);
    i_cdt_field_model.push(3, 1'b0);
    bus(1'b0, OFS_ELAPSED_TIME, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    meas(1, 1'b0, n);
    n = n + 4;
    check(32'(n >= (p2 - 1) * 4 && n <= (p2 + 1) * 4 + 8), 1);
    bus(1'b0, OFS_OFF_ELAPSED_TIME, 32'h0000_0000, q);
    check(q, 32'(p2));
    // Pulse timer in three resolutions, retriggered inside the pulse
    for (i = 0; i < 3; i++)
    begin
      u = (i == 0) ? 4 : (i == 1) ? 40 : 400;
      p = 2 + {$random(seed)} % 4;
      bus(1'b1, OFS_CTRL, CTRL_GO | (32'(i) << 15), q);
      bus(1'b1, OFS_PULSE_PRESET, 32'(p), q);
      i_cdt_field_model.push(4, 1'b1);
      meas(2, 1'b1, n);
      t = $time;
      check(32'(n <= 2), 1);
      i_cdt_field_model.push(4, 1'b0);
      // Early enough to land before the shortest possible pulse end
      repeat ((p - 1) * u / 2) @(posedge clk_sys);
      i_cdt_field_model.push(4, 1'b1);
      i_cdt_field_model.push(4, 1'b0);
      meas(2, 1'b0, n);
      n = int'(($time - t) / 20);
      ok = n >= (p - 1) * u && n <= (p + 1) * u + 4;
      check(32'(ok), 1);
      bus(1'b0, OFS_PULSE_ELAPSED, 32'h0000_0000, q);
      check(q, 32'(p));
    end
    // Count at zero, both timers idle, all buttons released
    bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
    check(q, 32'h0000_0089);
    results();
  end
endmodule
